/* File: src/bfq_pkg.sv */
// Package for the bidirectional inter-subsystem FIFO.
// Assumes one clock (i_clk, 200 MHz) and an asynchronous active-high reset.
package bfq_pkg;
  localparam int BFQ_DEPTH = 8;
  localparam int BFQ_WIDTH = 16;
  localparam int BFQ_PTR_W = 3;
  localparam int BFQ_CNT_W = 4;
  localparam logic [BFQ_CNT_W-1:0] BFQ_HALF_LEVEL = 4'h4;
  localparam logic [BFQ_CNT_W-1:0] BFQ_FULL_LEVEL = 4'h8;
  localparam int BFQ_WRITE_NS = 20;
  localparam int BFQ_READ_NS = 20;
  localparam int BFQ_CLK_PERIOD_PS = 5000;
  localparam int BFQ_WRITE_CYC = (BFQ_WRITE_NS * 1000 + BFQ_CLK_PERIOD_PS - 1) / BFQ_CLK_PERIOD_PS;
  localparam int BFQ_READ_CYC = (BFQ_READ_NS * 1000 + BFQ_CLK_PERIOD_PS - 1) / BFQ_CLK_PERIOD_PS;
  localparam int BFQ_TMR_W = 3;
  localparam int BFQ_IRQ_BIT_TX = 6;
  localparam int BFQ_IRQ_BIT_RX = 7;
  localparam int BFQ_IRQ_W = 16;
  localparam logic [1:0] BFQ_IRQ_OFF = 2'h0;
  localparam logic [1:0] BFQ_IRQ_HALF = 2'h1;
  localparam logic [1:0] BFQ_IRQ_FULL = 2'h2;
endpackage

/* File: src/bfq_port_if.sv */
// Interface between the top and one channel: a push side and a pop side.
// Assumes both sides are clocked by i_clk of the top.
`timescale 1ns/1ps
`default_nettype none
interface bfq_port_if;
  import bfq_pkg::*;
  logic push;
  logic [BFQ_WIDTH-1:0] push_data;
  logic not_full;
  logic pop;
  logic [BFQ_WIDTH-1:0] pop_data;
  logic not_empty;
  logic [BFQ_CNT_W-1:0] level;
  logic push_done;
  logic pop_done;
  modport chan (input push, push_data, pop, output not_full, pop_data, not_empty, level,
    push_done, pop_done);
  modport top (output push, push_data, pop, input not_full, pop_data, not_empty, level,
    push_done, pop_done);
endinterface
`default_nettype wire

/* File: src/bfq_chan.sv */
// One one-way channel: eight 16-bit entries with paced push and pop.
// Assumes push is only offered while not_full and pop while not_empty.
`timescale 1ns/1ps
`default_nettype none
module bfq_chan
  import bfq_pkg::*;
#(
  parameter int DEPTH = BFQ_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  bfq_port_if.chan port
);
  logic [BFQ_WIDTH-1:0] mem [DEPTH];
  logic [BFQ_PTR_W-1:0] wr_ptr;
  logic [BFQ_PTR_W-1:0] rd_ptr;
  logic [BFQ_CNT_W-1:0] count;
  logic [BFQ_TMR_W-1:0] wr_tmr;
  logic [BFQ_TMR_W-1:0] rd_tmr;
  logic do_push;
  logic do_pop;
  logic wr_busy;
  logic rd_busy;
  logic push_seen;
  logic pop_seen;
  logic do_fetch;

  assign wr_busy = wr_tmr != '0;
  assign rd_busy = rd_tmr != '0;
  // A write commits at the end of its pacing window, a read likewise
  assign do_push = wr_tmr == 3'h1;
  assign do_pop = rd_tmr == 3'h1;
  // Word fetched one cycle early so it stands beside the done pulse
  assign do_fetch = rd_tmr == 3'h2;

  // Requester still holds its strobe at the done edge; ignore it there
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      push_seen <= 1'b0;
      pop_seen <= 1'b0;
    end else begin
      push_seen <= do_push;
      pop_seen <= do_pop;
    end
  end

  // Writes accepted only with room left, reads only with data
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_tmr <= '0;
    end else if (wr_busy) begin
      wr_tmr <= wr_tmr - 3'h1;
    end else if (port.push && !push_seen && count != DEPTH[BFQ_CNT_W-1:0]) begin
      wr_tmr <= BFQ_TMR_W'(BFQ_WRITE_CYC);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_tmr <= '0;
    end else if (rd_busy) begin
      rd_tmr <= rd_tmr - 3'h1;
    end else if (port.pop && !pop_seen && count != '0 && !do_push) begin
      rd_tmr <= BFQ_TMR_W'(BFQ_READ_CYC);
    end
  end

  logic [BFQ_WIDTH-1:0] wr_hold;
  always_ff @(posedge i_clk) begin
    if (!wr_busy && !push_seen && port.push) begin
      wr_hold <= port.push_data;
    end
    if (do_push) begin
      mem[wr_ptr] <= wr_hold;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 3'h1;
      end
      // Simultaneous push and pop keep the level, so streaming never stops
      count <= count + BFQ_CNT_W'(do_push) - BFQ_CNT_W'(do_pop);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port.pop_data <= '0;
    end else if (do_fetch) begin
      port.pop_data <= mem[rd_ptr];
    end
  end

  // Flags drop while an operation is in flight so a word is neither lost nor doubled
  assign port.not_full = !wr_busy && count != DEPTH[BFQ_CNT_W-1:0];
  assign port.not_empty = !rd_busy && count != '0 && !do_push;
  assign port.level = count;
  assign port.push_done = do_push;
  assign port.pop_done = do_pop;
endmodule
`default_nettype wire

/* File: src/bfq_sync_irq.sv */
// Per-channel DMA interrupt generator on half or full fill.
// Assumes level and push_done come from the channel feeding that receiver.
`timescale 1ns/1ps
`default_nettype none
module bfq_sync_irq
  import bfq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_mode,
  input wire logic i_push_done,
  input wire logic [BFQ_CNT_W-1:0] i_level,
  output logic o_irq
);
  logic [BFQ_CNT_W-1:0] new_level;
  assign new_level = i_level + 4'h1;

  // Pulse once the fourth or eighth word has fully landed
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= i_push_done &&
        ((i_mode == BFQ_IRQ_HALF && new_level == BFQ_HALF_LEVEL) ||
         (i_mode == BFQ_IRQ_FULL && new_level == BFQ_FULL_LEVEL));
    end
  end
endmodule
`default_nettype wire

/* File: src/bfq_top.sv */
// Bidirectional inter-subsystem FIFO: two one-way channels between subsystems A and B.
// Assumes each DMA controller holds its request until served and waits on the sync events.
`timescale 1ns/1ps
`default_nettype none
module bfq_top
  import bfq_pkg::*;
#(
  parameter int DEPTH = BFQ_DEPTH,
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Subsystem A DMA, I/O space access
  input wire logic i_a_io_sel,
  input wire logic [ADDR_W-1:0] i_a_addr,
  input wire logic i_a_wr,
  input wire logic i_a_rd,
  input wire logic [BFQ_WIDTH-1:0] i_a_wdata,
  input wire logic [1:0] i_a_irq_mode,
  output logic [BFQ_WIDTH-1:0] o_a_rdata,
  output logic o_a_tx_not_full,
  output logic o_a_rx_not_empty,
  output logic o_a_wr_done,
  output logic o_a_rd_done,
  output logic [BFQ_IRQ_W-1:0] o_a_irq_flags,
  // Subsystem B DMA, I/O space access
  input wire logic i_b_io_sel,
  input wire logic [ADDR_W-1:0] i_b_addr,
  input wire logic i_b_wr,
  input wire logic i_b_rd,
  input wire logic [BFQ_WIDTH-1:0] i_b_wdata,
  input wire logic [1:0] i_b_irq_mode,
  output logic [BFQ_WIDTH-1:0] o_b_rdata,
  output logic o_b_tx_not_full,
  output logic o_b_rx_not_empty,
  output logic o_b_wr_done,
  output logic o_b_rd_done,
  output logic [BFQ_IRQ_W-1:0] o_b_irq_flags
);
  // ch_ab carries A to B, ch_ba carries B to A
  bfq_port_if ch_ab ();
  bfq_port_if ch_ba ();

  logic a_irq;
  logic b_irq;

  // Address deliberately unused: one shared location per side
  logic unused_addr;
  assign unused_addr = ^{i_a_addr, i_b_addr};

  // Only I/O space cycles reach the FIFO
  // DMA-driven requests, no CPU in the loop
  assign ch_ab.push = i_a_io_sel && i_a_wr;
  assign ch_ab.push_data = i_a_wdata;
  assign ch_ab.pop = i_b_io_sel && i_b_rd;
  assign ch_ba.push = i_b_io_sel && i_b_wr;
  assign ch_ba.push_data = i_b_wdata;
  assign ch_ba.pop = i_a_io_sel && i_a_rd;

  // Two identical channels, each DEPTH deep
  bfq_chan #(.DEPTH(DEPTH)) u_ab (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .port(ch_ab)
  );

  bfq_chan #(.DEPTH(DEPTH)) u_ba (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .port(ch_ba)
  );

  // Receive interrupts follow words landing in each side's incoming channel
  bfq_sync_irq u_irq_b (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_mode(i_b_irq_mode),
    .i_push_done(ch_ab.push_done),
    .i_level(ch_ab.level),
    .o_irq(b_irq)
  );

  bfq_sync_irq u_irq_a (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_mode(i_a_irq_mode),
    .i_push_done(ch_ba.push_done),
    .i_level(ch_ba.level),
    .o_irq(a_irq)
  );

  // Registered sync events; levels hold while DMA is busy elsewhere
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_a_tx_not_full <= 1'b1;
      o_b_tx_not_full <= 1'b1;
      o_a_rx_not_empty <= 1'b0;
      o_b_rx_not_empty <= 1'b0;
    end else begin
      o_a_tx_not_full <= ch_ab.not_full && !ch_ab.push;
      o_b_tx_not_full <= ch_ba.not_full && !ch_ba.push;
      o_a_rx_not_empty <= ch_ba.not_empty && !ch_ba.pop;
      o_b_rx_not_empty <= ch_ab.not_empty && !ch_ab.pop;
    end
  end

  // Completion strobes let the DMA step its element count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_a_wr_done <= 1'b0;
      o_b_wr_done <= 1'b0;
      o_a_rd_done <= 1'b0;
      o_b_rd_done <= 1'b0;
      o_a_rdata <= '0;
      o_b_rdata <= '0;
    end else begin
      o_a_wr_done <= ch_ab.push_done;
      o_b_wr_done <= ch_ba.push_done;
      o_a_rd_done <= ch_ba.pop_done;
      o_b_rd_done <= ch_ab.pop_done;
      o_a_rdata <= ch_ba.pop_data;
      o_b_rdata <= ch_ab.pop_data;
    end
  end

  // DMA channel 6 (transmit) and channel 7 (receive) interrupt bits
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_a_irq_flags <= '0;
      o_b_irq_flags <= '0;
    end else begin
      o_a_irq_flags <= '0;
      o_b_irq_flags <= '0;
      o_a_irq_flags[BFQ_IRQ_BIT_RX] <= a_irq;
      o_b_irq_flags[BFQ_IRQ_BIT_RX] <= b_irq;
      o_a_irq_flags[BFQ_IRQ_BIT_TX] <= ch_ab.push_done && ch_ab.level == 4'h7;
      o_b_irq_flags[BFQ_IRQ_BIT_TX] <= ch_ba.push_done && ch_ba.level == 4'h7;
    end
  end
endmodule
`default_nettype wire

/* File: verification/bfq_assertions.sv */
// Port checks for bfq_top: pacing, events, pulses, reset levels.
// Assumes one clock domain; bound to bfq_top below.
`timescale 1ns/1ps
`default_nettype none
module bfq_assertions
  import bfq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_a_io_sel,
  input wire logic i_a_wr,
  input wire logic i_b_rd,
  input wire logic [1:0] i_b_irq_mode,
  input wire logic o_a_tx_not_full,
  input wire logic o_b_rx_not_empty,
  input wire logic o_a_wr_done,
  input wire logic o_b_rd_done,
  input wire logic [BFQ_WIDTH-1:0] o_b_rdata,
  input wire logic [BFQ_IRQ_W-1:0] o_b_irq_flags,
  input wire logic [BFQ_IRQ_W-1:0] o_a_irq_flags
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wr_pace_a: assert property (o_a_wr_done |-> $past(i_a_io_sel && i_a_wr, 5))
    else $error("early write done");
  rd_pace_a: assert property (o_b_rd_done |-> $past(i_b_rd, 5))
    else $error("early read done");
  tx_hold_a: assert property (i_a_io_sel && i_a_wr && o_a_tx_not_full
    |=> !o_a_tx_not_full) else $error("not full kept during write");
  wr_pulse_a: assert property (o_a_wr_done |=> !o_a_wr_done)
    else $error("write done too long");
  a_to_b_a: assert property (o_a_wr_done && !i_b_rd |=> o_b_rx_not_empty)
    else $error("word not offered to B");
  flag_bits_a: assert property ((o_b_irq_flags & 16'hFF3F) == 16'h0000)
    else $error("stray interrupt bit");
  flag_bits_side_a: assert property ((o_a_irq_flags & 16'hFF3F) == 16'h0000)
    else $error("stray interrupt bit on side A");
  irq_mode_a: assert property (o_b_irq_flags[7] |-> i_b_irq_mode != 2'h0)
    else $error("interrupt while off");
  rdata_hold_a: assert property ($changed(o_b_rdata) |-> o_b_rd_done)
    else $error("read data moved");
  rst_level_a: assert property (disable iff (1'b0) i_rst |->
    o_a_tx_not_full && !o_b_rx_not_empty) else $error("bad events in reset");
endmodule
bind bfq_top bfq_assertions u_chk (.*);
`default_nettype wire

/* File: verification/bfq_dma_model.sv */
// Partner DMA of one subsystem: pushes a counted stream, pops into a queue.
// Assumes done pulses from bfq_top; the bench sets tgt, gap and rx_en.
`timescale 1ns/1ps
`default_nettype none
module bfq_dma_model #(
  parameter logic [15:0] BASE = 16'h0000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_room,
  input wire logic i_avail,
  input wire logic i_wr_done,
  input wire logic i_rd_done,
  input wire logic [15:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata
);
  int tgt = 0;
  int sent = 0;
  int gap = 0;
  bit rx_en = 1;
  logic [15:0] rxq[$];
  initial begin
    o_wr = 0;
    o_wdata = 16'h0000;
    forever begin
      @(posedge i_clk);
      if (!i_rst && i_room && sent < tgt) begin
        #1 o_wr = 1;
        o_wdata = BASE + 16'(sent);
        do @(posedge i_clk); while (!i_wr_done);
        #1 o_wr = 0;
        // Released bus shows no stale word
        o_wdata = ~o_wdata;
        // Element count steps once per delivered word
        sent++;
        repeat (gap) @(posedge i_clk);
      end
    end
  end
  initial begin
    o_rd = 0;
    forever begin
      @(posedge i_clk);
      if (!i_rst && i_avail && rx_en) begin
        #1 o_rd = 1;
        do @(posedge i_clk); while (!i_rd_done);
        rxq.push_back(i_rdata);
        #1 o_rd = 0;
        repeat (gap) @(posedge i_clk);
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/bfq_tb_top.sv */
// Bench for bfq_top: two partner DMAs, a table of streams, then edge cases.
// Assumes bfq_assertions is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module bfq_tb_top;
  logic i_clk, i_rst, i_a_io_sel, i_b_io_sel, i_a_wr, i_a_rd, i_b_wr, i_b_rd;
  logic [15:0] i_a_addr, i_b_addr, i_a_wdata, i_b_wdata, o_a_rdata, o_b_rdata;
  logic [15:0] o_a_irq_flags, o_b_irq_flags;
  logic [1:0] i_a_irq_mode, i_b_irq_mode;
  logic o_a_tx_not_full, o_a_rx_not_empty, o_a_wr_done, o_a_rd_done;
  logic o_b_tx_not_full, o_b_rx_not_empty, o_b_wr_done, o_b_rd_done;
  int error_cnt = 0, total_checks = 0, cyc = 0, irq_a = 0, irq_b = 0;
  // Words A to B, words B to A, gap, address
  int rows[4][4] = '{'{1, 1, 0, 0}, '{20, 20, 0, 16'h1234}, '{5, 3, 3, 16'hFFFF},
    '{0, 9, 1, 16'h0055}};
  bfq_top DUT (.*);
  bfq_dma_model #(.BASE(16'hA000)) m_a (.i_clk, .i_rst, .i_room(o_a_tx_not_full),
    .i_avail(o_a_rx_not_empty), .i_wr_done(o_a_wr_done), .i_rd_done(o_a_rd_done),
    .i_rdata(o_a_rdata), .o_wr(i_a_wr), .o_rd(i_a_rd), .o_wdata(i_a_wdata));
  bfq_dma_model #(.BASE(16'hB000)) m_b (.i_clk, .i_rst, .i_room(o_b_tx_not_full),
    .i_avail(o_b_rx_not_empty), .i_wr_done(o_b_wr_done), .i_rd_done(o_b_rd_done),
    .i_rdata(o_b_rdata), .o_wr(i_b_wr), .o_rd(i_b_rd), .o_wdata(i_b_wdata));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_all();
    foreach (m_b.rxq[i]) chk("a_to_b", 16'hA000 + 16'(i), m_b.rxq[i]);
    foreach (m_a.rxq[i]) chk("b_to_a", 16'hB000 + 16'(i), m_a.rxq[i]);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    i_clk = 0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      conclude();
    end
  end
  always @(posedge i_clk) if (o_b_irq_flags[7]) irq_b++;
  always @(posedge i_clk) if (o_a_irq_flags[6]) irq_a++;
  initial begin
    // Reset rises after time zero so the asynchronous branch surely fires
    i_rst = 0;
    i_a_io_sel = 1;
    i_b_io_sel = 1;
    i_a_addr = 16'h0000;
    i_b_addr = 16'h0000;
    i_a_irq_mode = 2'h0;
    i_b_irq_mode = 2'h0;
    #1 i_rst = 1;
    repeat (16) @(posedge i_clk);
    #1 i_rst = 0;
    foreach (rows[r]) begin
      @(posedge i_clk);
      #1 m_a.gap = rows[r][2];
      m_b.gap = rows[r][2];
      i_a_addr = 16'(rows[r][3]);
      i_b_addr = ~16'(rows[r][3]);
      m_a.tgt += rows[r][0];
      m_b.tgt += rows[r][1];
      wait (m_b.rxq.size() == m_a.tgt && m_a.rxq.size() == m_b.tgt);
      cmp_all();
    end
    chk("irq_off", 16'h0000, 16'(irq_b));
    @(posedge i_clk);
    #1 i_a_io_sel = 0;
    m_a.tgt += 1;
    repeat (20) @(posedge i_clk);
    chk("sel_low", 16'(m_a.tgt - 1), 16'(m_a.sent));
    #1 i_a_io_sel = 1;
    // Receiver stalled: ninth word must wait for room
    for (int m = 1; m < 3; m++) begin
      wait (m_b.rxq.size() == m_a.tgt);
      @(posedge i_clk);
      #1 i_b_irq_mode = 2'(m);
      i_a_irq_mode = 2'(m);
      m_b.rx_en = 0;
      irq_a = 0;
      irq_b = 0;
      m_a.tgt += 9;
      repeat (120) @(posedge i_clk);
      chk("sent", 16'(m_a.tgt - 1), 16'(m_a.sent));
      chk("full", 16'h0000, {15'h0000, o_a_tx_not_full});
      chk("rx_irq", 16'h0001, 16'(irq_b));
      chk("tx_irq", 16'h0001, 16'(irq_a));
      m_b.rx_en = 1;
    end
    wait (m_b.rxq.size() == m_a.tgt);
    cmp_all();
    @(posedge i_clk);
    #1 m_b.rx_en = 0;
    m_a.tgt += 3;
    wait (m_a.sent == m_a.tgt);
    @(posedge i_clk);
    #1 i_rst = 1;
    @(posedge i_clk);
    chk("rst_room", 16'h0001, {15'h0000, o_a_tx_not_full});
    chk("rst_avail", 16'h0000, {15'h0000, o_b_rx_not_empty});
    #1 i_rst = 0;
    m_b.rx_en = 1;
    repeat (20) @(posedge i_clk);
    chk("rst_drop", 16'(m_a.tgt - 3), 16'(m_b.rxq.size()));
    conclude();
  end
endmodule
`default_nettype wire
